// ### inc/ebc_regs.vh
/*
 * Constants of the external bus controller: register offsets, control field
 * positions, reset values and timing counts.
 * Assumes a 50 MHz system clock and a 32-bit plain register port.
 */
//
// Summary of operation
// R1 - ready high adds waitstate, low ends cycle
// R2 - partner may drop ready after strobe rises
// R3 - unsynced ready must stay low long enough
// R4 - programmed length and memory waits come first
// R5 - read/write delay sets strobe leading edge
// R6 - multiplexed mode adds wait, optional tristate wait
// R7 - gap two cycles muxed+tristate, one with either alone, else zero
// R8 - finish running cycle before granting bus
// R9 - regain starts only when hold released
// R10 - hold may drop without reclaim request
// R11 - release pins while granted, redrive before cycle
`ifndef EBC_REGS_VH
`define EBC_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// register map
`define EBC_ADDR_W          4
`define EBC_OFS_CTRL        4'h0
`define EBC_OFS_STATUS      4'h4
`define EBC_CTRL_RESET      32'h0000_0000

// control fields
`define EBC_CTRL_MUX        0
`define EBC_CTRL_TRI        1
`define EBC_CTRL_RWDLY      2
`define EBC_CTRL_RDYEN      3
`define EBC_CTRL_MCW_LO     4
`define EBC_CTRL_MCW_HI     7

// status fields
`define EBC_STAT_BUSY       0
`define EBC_STAT_GRANT      1
`define EBC_STAT_RECLAIM    2
`define EBC_STAT_ST_LO      8
`define EBC_STAT_ST_HI      16

////////////////////////////////////////////////////////////////////////////////
// timing
`define EBC_SYS_PERIOD_NS   20
`define EBC_BUSCLK_PERIOD_NS 40
`define EBC_BUSCLK_DIV      (`EBC_BUSCLK_PERIOD_NS / `EBC_SYS_PERIOD_NS)
`define EBC_MUX_TRI_GAP     2

`endif

// ### logic/ebc_bus_ctrl.v
/*
 * External bus controller: runs read and write cycles on the external
 * address/data pins with programmed waits, ready waitstates, multiplexed
 * and tristate waits, and hands the bus to an external master on hold.
 * Assumes a user port on sys_clk and asynchronous ready, hold and data pins.
 */
`timescale 1ns/1ps
`include "ebc_regs.vh"
module ebc_bus_ctrl (
  input  wire        sys_clk,
  input  wire        resetn,
  // register port
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // user request port
  input  wire        req_valid,
  input  wire        req_write,
  input  wire [15:0] req_addr,
  input  wire [15:0] req_wdata,
  output wire        req_ready,
  output reg         rsp_valid,
  output reg  [15:0] rsp_rdata,
  // external bus pins
  output wire        system_clock_out,
  output reg         ale_out,
  output reg         rd_n_out,
  output reg         wr_n_out,
  output reg         ctrl_oe,
  output reg  [15:0] bus_addr_out,
  output reg         bus_addr_oe,
  output reg  [15:0] bus_data_out,
  output reg         bus_data_oe,
  input  wire [15:0] bus_data_in,
  input  wire        ready_n_in,
  input  wire        hold_n_in,
  output reg         bus_yield_grant_n,
  output reg         bus_reclaim_request_n
);

  // one-hot states
  localparam [8:0] S_IDLE  = 9'h001;
  localparam [8:0] S_ADDR  = 9'h002;
  localparam [8:0] S_CMD   = 9'h004;
  localparam [8:0] S_RDY   = 9'h008;
  localparam [8:0] S_MUXW  = 9'h010;
  localparam [8:0] S_TRIW  = 9'h020;
  localparam [8:0] S_GRANT = 9'h040;
  localparam [8:0] S_REGN  = 9'h080;
  localparam [8:0] S_DRIVE = 9'h100;

  //////////////////////////////////////////////////////////////////////////////
  // clock divider and pin synchronisers
  // the bus clock and both tick pulses come from one counter, so they stay in step
  wire        rise_tick;
  wire        fall_tick;
  wire        ready_n_s;
  wire        hold_n_s;
  wire [15:0] data_in_s;

  ebc_clkdiv u_div (
    .sys_clk          (sys_clk),
    .resetn           (resetn),
    .rise_tick        (rise_tick),
    .fall_tick        (fall_tick),
    .system_clock_out (system_clock_out)
  );

  // ready and hold come out of reset at their idle high level, so the
  // first cycles after reset see neither a false end nor a false hold
  ebc_sync2 #(.WIDTH(18), .INIT(18'h3_0000)) u_sync (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .async_in ({ready_n_in, hold_n_in, bus_data_in}),
    .sync_out ({ready_n_s, hold_n_s, data_in_s})
  );

  //////////////////////////////////////////////////////////////////////////////
  // control register
  reg  [31:0] ctrl_reg;
  wire        mux_mode = ctrl_reg[`EBC_CTRL_MUX];
  wire        tri_en   = ctrl_reg[`EBC_CTRL_TRI];
  wire        rw_delay = ctrl_reg[`EBC_CTRL_RWDLY];
  wire        ready_en = ctrl_reg[`EBC_CTRL_RDYEN];
  wire [3:0]  mcw_num  = ctrl_reg[`EBC_CTRL_MCW_HI:`EBC_CTRL_MCW_LO];

  // software write of the control word
  // only the low byte is stored; the upper bits always read back as zero
  always @(posedge sys_clk) begin
    if (!resetn)
      ctrl_reg <= `EBC_CTRL_RESET;
    else if (reg_wr && reg_addr == `EBC_OFS_CTRL)
      ctrl_reg <= {24'h00_0000, reg_wdata[7:0]};
  end

  //////////////////////////////////////////////////////////////////////////////
  // state registers
  reg [8:0]  state_reg;
  reg [8:0]  state_next;
  reg [3:0]  wait_reg;
  reg [3:0]  wait_next;
  reg        write_reg;
  reg [15:0] addr_reg;
  reg [15:0] wdata_reg;
  reg        strobe_arm_reg;
  reg        hold_prev_reg;

  // hold_rise marks the cycle in which the synchronised hold line goes high
  wire hold_req  = !hold_n_s;
  wire hold_rise = hold_n_s && !hold_prev_reg;  // hold released this cycle
  wire in_cycle  = |(state_reg & (S_ADDR | S_CMD | S_RDY));

  // a new request is only taken in idle on a bus clock edge with no hold;
  // a hold seen in idle wins over a waiting user request, and the user
  // request then waits for the regain
  assign req_ready = state_reg[0] && rise_tick && !hold_req;

  // next state, advanced on rising edges of the bus clock
  always @* begin
    state_next = state_reg;
    wait_next  = wait_reg;
    if (rise_tick) begin
      case (state_reg)
        S_IDLE: begin
          if (hold_req)
            state_next = S_GRANT;              // see R8
          else if (req_valid)
            state_next = S_ADDR;
        end
        S_ADDR: begin
          state_next = S_CMD;
          wait_next  = mcw_num;                // see R4
        end
        // memory waits count down one bus clock each
        S_CMD: begin
          if (wait_reg != 4'h0)
            wait_next = wait_reg - 4'h1;       // see R4
          else
            state_next = S_RDY;
        end
        S_RDY: begin
          // sample point: high adds a waitstate, low ends the cycle
          if (!ready_en || !ready_n_s)         // see R1
            state_next = mux_mode ? S_MUXW : (tri_en ? S_TRIW : S_IDLE); // see R6, R7
        end
        S_MUXW: begin
          state_next = tri_en ? S_TRIW : S_IDLE;  // see R6
        end
        S_TRIW: begin
          state_next = S_IDLE;                 // see R7
        end
        // granted: stay until the hold line is seen released
        S_GRANT: begin
          if (hold_n_s)
            state_next = S_REGN;               // see R9, R10
        end
        S_REGN: begin
          state_next = S_DRIVE;                // see R11
        end
        S_DRIVE: begin
          state_next = S_IDLE;                 // see R11
        end
        default: begin
          state_next = S_IDLE;
        end
      endcase
    end
  end

  // state, request latches and hold edge memory
  always @(posedge sys_clk) begin
    if (!resetn) begin
      state_reg     <= S_IDLE;
      wait_reg      <= 4'h0;
      write_reg     <= 1'b0;
      addr_reg      <= 16'h0000;
      wdata_reg     <= 16'h0000;
      hold_prev_reg <= 1'b1;
    end else begin
      state_reg     <= state_next;
      wait_reg      <= wait_next;
      hold_prev_reg <= hold_n_s;
      if (req_ready && req_valid) begin
        write_reg <= req_write;
        addr_reg  <= req_addr;
        wdata_reg <= req_wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // strobe leading edge: with read/write delay the strobe waits for the
  // falling bus clock edge of the first command phase
  always @(posedge sys_clk) begin
    if (!resetn)
      strobe_arm_reg <= 1'b0;
    else if (!(state_reg[2] || state_reg[3]))
      strobe_arm_reg <= 1'b0;
    else if (fall_tick)
      strobe_arm_reg <= 1'b1;                  // see R5
  end

  wire strobe_on = (state_reg[2] || state_reg[3]) && (!rw_delay || strobe_arm_reg); // see R5
  wire end_cycle = state_reg[3] && rise_tick && (!ready_en || !ready_n_s);          // see R1
  // the pins stay released through the grant and the first regain tick,
  // and are driven again two bus clocks before a new cycle may start
  wire owned     = !(state_reg[6] || state_reg[7]);

  //////////////////////////////////////////////////////////////////////////////
  // pin outputs, all registered
  // so each pin lags the state by one sys_clk and never glitches
  always @(posedge sys_clk) begin
    if (!resetn) begin
      ale_out      <= 1'b0;
      rd_n_out     <= 1'b1;
      wr_n_out     <= 1'b1;
      ctrl_oe      <= 1'b1;
      bus_addr_out <= 16'h0000;
      bus_addr_oe  <= 1'b1;
      bus_data_out <= 16'h0000;
      bus_data_oe  <= 1'b0;
    end else begin
      ale_out      <= state_reg[1];
      rd_n_out     <= !(strobe_on && !write_reg);
      wr_n_out     <= !(strobe_on && write_reg);
      ctrl_oe      <= owned;                   // see R11
      bus_addr_out <= addr_reg;
      bus_addr_oe  <= owned;                   // see R11
      // multiplexed mode puts the address on the data pins during ale
      if (mux_mode && state_reg[1])
        bus_data_out <= addr_reg;
      else
        bus_data_out <= wdata_reg;
      bus_data_oe  <= owned && ((mux_mode && state_reg[1])
                      || (write_reg && (state_reg[2] || state_reg[3])));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // arbitration pins: grant held through the granted phase, reclaim
  // request raised while a user request waits for the bus; it is dropped
  // in the cycle the hold release is seen, and comes back for one cycle if the grant state outlasts that cycle
  always @(posedge sys_clk) begin
    if (!resetn) begin
      bus_yield_grant_n     <= 1'b1;
      bus_reclaim_request_n <= 1'b1;
    end else begin
      bus_yield_grant_n     <= !state_reg[6];              // see R8, R11
      bus_reclaim_request_n <= !(state_reg[6] && req_valid && !hold_rise); // see R9
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read answer: the data pins reach data_in_s two cycles late, so the
  // answer is taken two cycles after the cycle ends; data_in_s then holds
  // what the pins showed up to the strobe's trailing edge, not its start
  reg [1:0] end_dly_reg;

  always @(posedge sys_clk) begin
    if (!resetn) begin
      end_dly_reg <= 2'b00;
      rsp_valid   <= 1'b0;
      rsp_rdata   <= 16'h0000;
    end else begin
      end_dly_reg <= {end_dly_reg[0], end_cycle};
      rsp_valid   <= end_dly_reg[1];
      // write_reg still belongs to this cycle: the next request is taken
      // no earlier than this edge
      if (end_dly_reg[1] && !write_reg)
        rsp_rdata <= data_in_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status word: cycle, grant and reclaim flags in the low bits, the
  // one-hot state above them for debug
  wire [31:0] status_word = {15'h0000, state_reg, 5'h00,
                             !bus_reclaim_request_n,
                             !bus_yield_grant_n, in_cycle};

  //////////////////////////////////////////////////////////////////////////////
  // register read port, data in the cycle after the strobe
  always @(posedge sys_clk) begin
    if (!resetn)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd) begin
      case (reg_addr)
        `EBC_OFS_CTRL:   reg_rdata <= ctrl_reg;
        `EBC_OFS_STATUS: reg_rdata <= status_word;
        default:         reg_rdata <= 32'h0000_0000;
      endcase
    end else
      reg_rdata <= 32'h0000_0000;
  end

endmodule

// ### logic/ebc_clkdiv.v
/*
 * Bus clock divider: makes the visible bus clock and enable pulses
 * for its rising and falling edges.
 * Assumes the bus clock period is a whole even multiple of sys_clk.
 */
`timescale 1ns/1ps
`include "ebc_regs.vh"
module ebc_clkdiv (
  input  wire sys_clk,
  input  wire resetn,
  output wire rise_tick,
  output wire fall_tick,
  output wire system_clock_out
);

  localparam integer DIV    = `EBC_BUSCLK_DIV;
  localparam integer LAST_I = DIV - 1;
  localparam integer HALF_I = DIV / 2 - 1;
  localparam [3:0]   LAST   = LAST_I[3:0];
  localparam [3:0]   HALF   = HALF_I[3:0];

  reg [3:0] cnt_reg;
  reg       clk_reg;

  // count sys_clk cycles, toggle the bus clock at each half period
  always @(posedge sys_clk) begin
    if (!resetn) begin
      cnt_reg <= 4'h0;
      clk_reg <= 1'b0;
    end else begin
      cnt_reg <= (cnt_reg == LAST) ? 4'h0 : cnt_reg + 4'h1;
      if (cnt_reg == LAST)
        clk_reg <= 1'b1;
      else if (cnt_reg == HALF)
        clk_reg <= 1'b0;
    end
  end

  assign rise_tick        = (cnt_reg == LAST);  // bus clock rises next edge
  assign fall_tick        = (cnt_reg == HALF);  // bus clock falls next edge
  assign system_clock_out = clk_reg;

endmodule

// ### logic/ebc_sync2.v
/*
 * Two-stage synchroniser for pin inputs, one stage pair per bit.
 * Assumes the inputs are asynchronous to sys_clk.
 */
`timescale 1ns/1ps
module ebc_sync2 #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input  wire             sys_clk,
  input  wire             resetn,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_reg;
      reg stable_reg;
      // first stage feeds only the second stage
      always @(posedge sys_clk) begin
        if (!resetn) begin
          meta_reg   <= INIT[i];
          stable_reg <= INIT[i];
        end else begin
          meta_reg   <= async_in[i];
          stable_reg <= meta_reg;
        end
      end
      assign sync_out[i] = stable_reg;
    end
  endgenerate

endmodule

// ### tb/ebc_bus_ctrl_tb.sv
/* testbench for the bus controller: registers, cycle lengths, ready and hold.
   assumes the far side model and checker of this folder. */
`timescale 1ns/1ps
`include "ebc_regs.vh"
module ebc_bus_ctrl_tb;
  logic        sys_clk, resetn, reg_wr, reg_rd, req_valid, req_write, req_ready;
  logic        rsp_valid, system_clock_out, ale_out, rd_n_out, wr_n_out, ctrl_oe;
  logic        bus_addr_oe, bus_data_oe, ready_n_in, hold_n_in, hold_req;
  logic        bus_yield_grant_n, bus_reclaim_request_n;
  logic [3:0]  reg_addr;
  logic [7:0]  ready_dly;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] req_addr, req_wdata, rsp_rdata, bus_addr_out, bus_data_out, bus_data_in;
  int          n_fail, num_checks, n, g, s, l, b, bs, k;
  logic [7:0]  ctl [5] = '{8'h00, 8'h01, 8'h03, 8'h30, 8'h04};
  int          dt [5] = '{0, 2, 4, 6, 0};
  int          ds [5] = '{0, 0, 0, 0, 1};
  ebc_bus_ctrl i_ebc_bus_ctrl (.*);
  ebc_far_model i_ebc_far_model (.*);
  //////////////////////////////////////////////////////////////////////////////
  // compare and bus tasks
  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("BAD %0t count %0d", $time, got);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk_v(reg_rdata, e);
  endtask
  // one bus cycle: n to response, s to strobe, l strobe length, g from accept to next accept
  task automatic op(input logic w, input logic [15:0] a);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= ~a;
    do @(negedge sys_clk); while (req_ready !== 1'b1);
    @(posedge sys_clk);
    req_valid <= 1'b0;
    n = 0;
    s = 0;
    l = 0;
    g = 0;
    do begin
      @(posedge sys_clk);
      #1 n++;
      if (!(rd_n_out && wr_n_out)) begin
        l++;
        if (s == 0) s = n;
        if (w && s == n) chk_v({bus_data_oe, bus_data_out}, {1'b1, ~a});
      end
      if (n == 1) chk_v({ale_out, bus_addr_out}, {1'b1, a});
      if (g == 0 && req_ready === 1'b1) g = n;
    end while (rsp_valid !== 1'b1 && n < 200);
    chk_v(rsp_valid, 1'b1);
    if (!w) chk_v(rsp_rdata, a ^ 16'hA5C3);
    while (!hold_req && g == 0 && n < 250) begin
      @(posedge sys_clk);
      #1 n++;
      if (req_ready === 1'b1) g = n;
    end
    if (!hold_req) chk_n(g, 1, 250);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    finish_test;
  end
  // main sequence
  initial begin
    {resetn, reg_wr, reg_rd, req_valid, req_write, hold_req} = 6'h00;
    {reg_addr, reg_wdata, req_addr, req_wdata, ready_dly} = 76'h0;
    n_fail = 0;
    num_checks = 0;
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    rd_reg(`EBC_OFS_CTRL, `EBC_CTRL_RESET);
    rd_reg(`EBC_OFS_STATUS, 32'h0000_0100);
    wr_reg(`EBC_OFS_CTRL, 32'hFFFF_FF5A);
    rd_reg(`EBC_OFS_CTRL, 32'h0000_005A);
    rd_reg(4'h8, 32'h0000_0000);
    for (k = 0; k < 5; k++) begin
      wr_reg(`EBC_OFS_CTRL, {24'h000000, ctl[k]});
      op(1'b0, 16'h0100 + k[15:0]);
      if (k == 0) begin
        b = g;
        bs = s;
      end
      chk_n(g, b + dt[k], b + dt[k]);
      chk_n(s, bs + ds[k], bs + ds[k]);
      op(1'b1, 16'h0200);
    end
    wr_reg(`EBC_OFS_CTRL, 32'h0000_0008);
    ready_dly <= 8'h0C;
    op(1'b0, 16'h0300);
    chk_n(l, 12, 20);
    ready_dly <= 8'h00;
    op(1'b0, 16'h0310);
    chk_n(l, 1, 8);
    wr_reg(`EBC_OFS_CTRL, 32'h0000_0000);
    for (k = 0; k < 2; k++) begin
      fork
        op(1'b0, 16'h0400);
        begin
          @(posedge sys_clk iff rd_n_out === 1'b0);
          hold_req <= 1'b1;
        end
      join
      repeat (12) @(posedge sys_clk);
      #1 chk_v(bus_yield_grant_n, 1'b0);
      chk_v(bus_addr_oe, 1'b0);
      rd_reg(`EBC_OFS_STATUS, 32'h0000_4002);
      if (k == 1) begin
        fork
          op(1'b1, 16'h0500);
          begin
            repeat (8) @(posedge sys_clk);
            #1 chk_v(bus_reclaim_request_n, 1'b0);
            hold_req <= 1'b0;
          end
        join
      end else begin
        hold_req <= 1'b0;
        repeat (12) @(posedge sys_clk);
        #1 chk_v(bus_yield_grant_n, 1'b1);
        chk_v(bus_addr_oe, 1'b1);
      end
    end
    op(1'b0, 16'h0600);
    finish_test;
  end
endmodule
bind ebc_bus_ctrl ebc_chk i_ebc_chk (.*);

// ### tb/ebc_chk_sva.sv
/* pin and handshake checker for the external bus controller.
   assumes binding to ebc_bus_ctrl, one clock domain. */
`timescale 1ns/1ps
module ebc_chk (
  input wire sys_clk,
  input wire resetn,
  input wire req_valid,
  input wire req_ready,
  input wire rsp_valid,
  input wire system_clock_out,
  input wire rd_n_out,
  input wire wr_n_out,
  input wire ctrl_oe,
  input wire bus_addr_oe,
  input wire bus_data_oe,
  input wire hold_n_in,
  input wire bus_yield_grant_n,
  input wire bus_reclaim_request_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  //////////////////////////////////////////////////////////////////////////////
  // arbitration
  grant_no_strobe_a: assert property ($fell(bus_yield_grant_n) |-> rd_n_out && wr_n_out)
    else $error("grant while strobe active");
  grant_no_accept_a: assert property (!bus_yield_grant_n |-> !req_ready)
    else $error("request taken while granted");
  regain_on_hold_a: assert property ($rose(bus_yield_grant_n) |-> $past(hold_n_in, 2))
    else $error("regain without hold release");
  reclaim_granted_a: assert property ($fell(bus_reclaim_request_n) |-> !bus_yield_grant_n)
    else $error("reclaim outside grant");
  granted_float_a: assert property (!bus_yield_grant_n && !$past(bus_yield_grant_n)
    |-> !(bus_addr_oe || ctrl_oe || bus_data_oe))
    else $error("pins driven while granted");
  regain_drive_a: assert property ($rose(bus_yield_grant_n) |-> ##[1:6] (bus_addr_oe && ctrl_oe))
    else $error("pins not redriven");
  accept_driven_a: assert property (req_valid && req_ready |-> bus_addr_oe && ctrl_oe)
    else $error("cycle starts on released pins");
  //////////////////////////////////////////////////////////////////////////////
  // cycle end and bus clock
  strobe_end_a: assert property ($rose(rd_n_out) || $rose(wr_n_out) |-> ##[0:3] rsp_valid)
    else $error("strobe end without response");
  clk_toggle_a: assert property ($past(resetn, 2) |-> system_clock_out != $past(system_clock_out))
    else $error("bus clock stalled");
endmodule

// ### tb/ebc_far_model.sv
/* far side: memory answering reads and driving ready, plus the hold line
   of an external master. assumes the bench sets ready delay and hold. */
`timescale 1ns/1ps
module ebc_far_model (
  input  wire        sys_clk,
  input  wire        rd_n_out,
  input  wire        wr_n_out,
  input  wire [15:0] bus_addr_out,
  input  wire [7:0]  ready_dly,
  input  wire        hold_req,
  output reg  [15:0] bus_data_in,
  output reg         ready_n_in,
  output reg         hold_n_in
);
  reg [7:0] cnt_reg;
  initial begin
    bus_data_in = 16'h0000;
    ready_n_in = 1'b1;
    hold_n_in = 1'b1;
    cnt_reg = 8'h00;
  end
  // read data while selected, else a changing pattern; hold may drop any time
  always @(posedge sys_clk) begin
    bus_data_in <= !rd_n_out ? bus_addr_out ^ 16'hA5C3 : ~bus_data_in;
    hold_n_in <= !hold_req;
  end
  // ready low after the delay, removed on the strobe trailing edge
  always @(posedge sys_clk) begin
    if (rd_n_out && wr_n_out) begin
      cnt_reg <= 8'h00;
      ready_n_in <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
      if (cnt_reg >= ready_dly) ready_n_in <= 1'b0;
    end
  end
endmodule
